// ---- hdl/ais_defines.svh ----
// Summary of operation
// (RL1) Single-ended result is unsigned 10-bit code
// (RL2) Single-ended code is Vin*1024/Vref truncated
// (RL3) Differential result scales difference by gain*512/Vref
// (RL4) Differential codes are two's complement -512..+511
// (RL5) Result top bit gives differential sign
// (RL6) Result bytes readable once done flag high
// (RL7) Select bits 7:6 choose the reference
// (RL8) Reference write deferred until conversion completes
// (RL9) Bit 5 chooses left or right justification
// (RL10) Justification change reformats result immediately
// (RL11) Channel/gain write deferred until conversion completes
// (RL12) Codes 0-7 select single-ended inputs 0-7
// (RL13) Codes 8-15 select gain-stage differential pairs
// (RL14) Codes 16-29 select unity-gain differential pairs
// (RL15) Code 30 bandgap, code 31 ground
// (RL16) Done flag sets when result bytes update; the code sets it on every finish, also while the read lock blocks the update
// (RL17) Low byte read locks result until high read
// (RL18) Justified byte layout of result bits
// (RL19) Unused result byte bits read zero
// (RL20) Analog selections are registered, loaded when idle
`ifndef AIS_DEFINES_SVH
`define AIS_DEFINES_SVH

// ====================================================
// Register byte addresses
`define AIS_ADDR_SELECT      12'h000
`define AIS_ADDR_CTRL        12'h004
`define AIS_ADDR_RES_LOW     12'h008
`define AIS_ADDR_RES_HIGH    12'h00c

// ====================================================
// Select register fields and reset
`define AIS_SEL_REF_HI       7
`define AIS_SEL_REF_LO       6
`define AIS_SEL_LJ_BIT       5
`define AIS_SEL_MUX_HI       4
`define AIS_SEL_RESET        8'h00

// ====================================================
// Control register fields
`define AIS_CTL_START_BIT    0
`define AIS_CTL_DONE_BIT     1
`define AIS_CTL_BUSY_BIT     2

// ====================================================
// Result encodings
`define AIS_RES_ZERO         10'h000
`define AIS_RES_MAX          10'h3ff
`define AIS_SIGN_BIT         9
`define AIS_CODE_SE_LAST     5'h07
`define AIS_CODE_G10_FIRST   5'h08
`define AIS_CODE_U1_FIRST    5'h10
`define AIS_CODE_U2_FIRST    5'h18
`define AIS_CODE_U2_LAST     5'h1d
`define AIS_CODE_BANDGAP     5'h1e
`define AIS_CODE_GROUND      5'h1f
`define AIS_INPUT_ONE        3'h1
`define AIS_INPUT_TWO        3'h2
`define AIS_INPUT_ZERO       3'h0

`endif

// ---- hdl/ais_pkg.sv ----
package ais_pkg;
	// Reference choice presented to the analog side
	typedef enum logic [1:0] {
		AIS_REF_EXT      = 2'b00,
		AIS_REF_SUPPLY   = 2'b01,
		AIS_REF_RESERVED = 2'b10,
		AIS_REF_INT      = 2'b11
	} ais_ref_t;
	// Gain stage setting
	typedef enum logic [1:0] {
		AIS_GAIN_1   = 2'b00,
		AIS_GAIN_10  = 2'b01,
		AIS_GAIN_200 = 2'b10
	} ais_gain_t;
	// Source kind for single-ended routing
	typedef enum logic [1:0] {
		AIS_SRC_PIN     = 2'b00,
		AIS_SRC_DIFF    = 2'b01,
		AIS_SRC_BANDGAP = 2'b10,
		AIS_SRC_GROUND  = 2'b11
	} ais_src_t;
	// Conversion sequencer states
	typedef enum logic [1:0] {
		AIS_ST_IDLE = 2'b00,
		AIS_ST_CONV = 2'b01,
		AIS_ST_DONE = 2'b10
	} ais_state_t;
endpackage

// ---- hdl/ais_chan_decode.sv ----
`timescale 1ns/1ns
`include "ais_defines.svh"
// ====================================================
// Channel/gain code decoder
module ais_chan_decode
	import ais_pkg::*;
(
	input  wire logic [4:0] code,
	output logic      [2:0] pos_input,
	output logic      [2:0] neg_input,
	output ais_gain_t       gain,
	output ais_src_t        src
);
	// Group of the code
	wire is_se   = (code <= `AIS_CODE_SE_LAST);
	wire is_gain = (code >= `AIS_CODE_G10_FIRST) && (code < `AIS_CODE_U1_FIRST);
	wire is_u1   = (code >= `AIS_CODE_U1_FIRST) && (code < `AIS_CODE_U2_FIRST);
	wire is_u2   = (code >= `AIS_CODE_U2_FIRST) && (code <= `AIS_CODE_U2_LAST);

	// Gain pairs: bit0 picks odd pin, bit1 picks 200x, bit2 picks pins 2/3
	wire [2:0] gain_pos = {1'b0, code[2], code[0]};   // RL13
	wire [2:0] gain_neg = {1'b0, code[2], 1'b0};

	assign pos_input = (is_se || is_u1 || is_u2) ? code[2:0] : (is_gain ? gain_pos : `AIS_INPUT_ZERO); // RL12 RL14
	assign neg_input = is_gain ? gain_neg : (is_u1 ? `AIS_INPUT_ONE : (is_u2 ? `AIS_INPUT_TWO : `AIS_INPUT_ZERO)); // RL14
	assign gain = is_gain ? (code[1] ? AIS_GAIN_200 : AIS_GAIN_10) : AIS_GAIN_1; // RL13
	assign src  = is_se ? AIS_SRC_PIN
		: (code == `AIS_CODE_BANDGAP) ? AIS_SRC_BANDGAP   // RL15
		: (code == `AIS_CODE_GROUND) ? AIS_SRC_GROUND
		: AIS_SRC_DIFF;
endmodule // ais_chan_decode

// ---- hdl/ais_top.sv ----
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ns
`include "ais_defines.svh"
// ====================================================
// Converter input select and result formatting
module ais_top
	import ais_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        conv_finish,
	input  wire logic [9:0]  conv_code,
	output logic             conv_start,
	output ais_ref_t         reference_select,
	output logic      [2:0]  pos_input,
	output logic      [2:0]  neg_input,
	output ais_gain_t        gain_select,
	output ais_src_t         source_kind,
	output logic             diff_mode,
	output logic             conversion_done_flag
);
	// ====================================================
	// Register state
	logic [7:0]  sel_reg;
	ais_ref_t    ref_reg;
	logic [4:0]  mux_reg;
	logic [9:0]  result_reg;
	logic        done_reg;
	logic        lock_reg;
	logic        busy_reg;
	logic        start_reg;
	ais_state_t  state_reg;
	logic [31:0] rdata_reg;
	logic        ready_reg;
	logic        err_reg;
	logic [2:0]  pos_reg;
	logic [2:0]  neg_reg;
	ais_gain_t   gain_reg;
	ais_src_t    src_reg;
	logic        diff_reg;
	logic        fin_s1_reg;
	logic        fin_s2_reg;
	logic [9:0]  code_s1_reg;
	logic [9:0]  code_s2_reg;

	// ====================================================
	// Bus decode
	wire setup_ph  = psel && !penable;
	// Writes land at the edge that sees pready high, reads capture in setup
	wire access_ph = psel && penable && ready_reg;
	wire wr_en     = access_ph && pwrite;
	wire rd_en     = setup_ph && !pwrite;
	wire hit_sel   = (paddr == `AIS_ADDR_SELECT);
	wire hit_ctl   = (paddr == `AIS_ADDR_CTRL);
	wire hit_lo    = (paddr == `AIS_ADDR_RES_LOW);
	wire hit_hi    = (paddr == `AIS_ADDR_RES_HIGH);
	wire hit_any   = hit_sel || hit_ctl || hit_lo || hit_hi;
	wire wr_sel    = wr_en && hit_sel;
	wire wr_ctl    = wr_en && hit_ctl;
	wire rd_lo     = rd_en && hit_lo;
	wire rd_hi     = rd_en && hit_hi;
	wire start_req = wr_ctl && pwdata[`AIS_CTL_START_BIT] && !busy_reg;
	wire done_clr  = wr_ctl && pwdata[`AIS_CTL_DONE_BIT];

	// ====================================================
	// Result formatting, follows justification live
	wire left_j = sel_reg[`AIS_SEL_LJ_BIT];                      // RL9 RL10
	wire [15:0] res_word = left_j ? {result_reg, 6'h00}           // RL18 RL19
		: {6'h00, result_reg};
	wire [7:0] low_byte  = res_word[7:0];
	wire [7:0] high_byte = res_word[15:8];
	wire [7:0] ctl_byte  = {5'h00, busy_reg, done_reg, 1'b0};

	wire [31:0] rd_mux = hit_sel ? {24'h000000, sel_reg}
		: hit_ctl ? {24'h000000, ctl_byte}
		: hit_lo ? {24'h000000, low_byte}                         // RL6
		: hit_hi ? {24'h000000, high_byte}
		: 32'h00000000;

	// ====================================================
	// Finish pulse from analog side, synchronised
	wire fin_edge = fin_s2_reg && busy_reg && (state_reg == AIS_ST_CONV);

	// Result update is blocked between low and high reads
	wire upd_ok = fin_edge && !lock_reg;                          // RL17

	// Clamp code to 10-bit range
	wire [9:0] clamped = (code_s2_reg > `AIS_RES_MAX) ? `AIS_RES_MAX : code_s2_reg; // RL1 RL2

	// ====================================================
	// Channel decode of the written selection in sel_reg, before the idle load
	logic [2:0] dec_pos;
	logic [2:0] dec_neg;
	ais_gain_t  dec_gain;
	ais_src_t   dec_src;
	ais_chan_decode u_dec (
		.code      (sel_reg[`AIS_SEL_MUX_HI:0]),
		.pos_input (dec_pos),
		.neg_input (dec_neg),
		.gain      (dec_gain),
		.src       (dec_src)
	);
	wire idle_load = !busy_reg;                                   // RL8 RL11 RL20

	// ====================================================
	// Bus slave: answers in the access phase, one wait-free cycle
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_reg <= 32'h00000000;
			ready_reg <= 1'b0;
			err_reg   <= 1'b0;
		end else begin
			ready_reg <= setup_ph;
			err_reg   <= setup_ph && !hit_any;
			rdata_reg <= rd_en ? rd_mux : 32'h00000000;
		end
	end

	// Select register
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sel_reg <= `AIS_SEL_RESET;
		end else if (wr_sel) begin
			sel_reg <= pwdata[7:0];
		end
	end

	// Registered analog selections, loaded only while idle
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ref_reg  <= AIS_REF_EXT;
			mux_reg  <= 5'h00;
			pos_reg  <= 3'h0;
			neg_reg  <= 3'h0;
			gain_reg <= AIS_GAIN_1;
			src_reg  <= AIS_SRC_PIN;
			diff_reg <= 1'b0;
		end else if (idle_load) begin
			ref_reg  <= ais_ref_t'(sel_reg[`AIS_SEL_REF_HI:`AIS_SEL_REF_LO]); // RL7 RL8
			mux_reg  <= sel_reg[`AIS_SEL_MUX_HI:0];                          // RL11
			pos_reg  <= dec_pos;
			neg_reg  <= dec_neg;
			gain_reg <= dec_gain;
			src_reg  <= dec_src;
			diff_reg <= (dec_src == AIS_SRC_DIFF);                            // RL3
		end
	end

	// Synchroniser for finish and code from analog side
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			fin_s1_reg  <= 1'b0;
			fin_s2_reg  <= 1'b0;
			code_s1_reg <= 10'h000;
			code_s2_reg <= 10'h000;
		end else begin
			fin_s1_reg  <= conv_finish;
			fin_s2_reg  <= fin_s1_reg;
			code_s1_reg <= conv_code;
			code_s2_reg <= code_s1_reg;
		end
	end

	// Conversion sequencer
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= AIS_ST_IDLE;
			busy_reg  <= 1'b0;
			start_reg <= 1'b0;
		end else begin
			start_reg <= 1'b0;
			case (state_reg)
				AIS_ST_IDLE: begin
					if (start_req) begin
						state_reg <= AIS_ST_CONV;
						busy_reg  <= 1'b1;
						start_reg <= 1'b1;
					end
				end
				AIS_ST_CONV: begin
					if (fin_edge) begin
						state_reg <= AIS_ST_DONE;
					end
				end
				AIS_ST_DONE: begin
					if (!fin_s2_reg) begin
						state_reg <= AIS_ST_IDLE;
						busy_reg  <= 1'b0;
					end
				end
				default: begin
					state_reg <= AIS_ST_IDLE;
					busy_reg  <= 1'b0;
				end
			endcase
		end
	end

	// Result, done flag and read lock
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			result_reg <= `AIS_RES_ZERO;
			done_reg   <= 1'b0;
			lock_reg   <= 1'b0;
		end else begin
			if (upd_ok) begin
				result_reg <= clamped;                                // RL4 RL5
			end
			if (fin_edge) begin
				done_reg <= 1'b1;                                     // RL16
			end else if (done_clr) begin
				done_reg <= 1'b0;
			end
			if (rd_hi) begin
				lock_reg <= 1'b0;                                     // RL17
			end else if (rd_lo) begin
				lock_reg <= 1'b1;
			end
		end
	end

	// ====================================================
	// Outputs
	assign prdata               = rdata_reg;
	assign pready               = ready_reg;
	assign pslverr              = err_reg;
	assign conv_start           = start_reg;
	assign reference_select     = ref_reg;
	assign pos_input            = pos_reg;
	assign neg_input            = neg_reg;
	assign gain_select          = gain_reg;
	assign source_kind          = src_reg;
	assign diff_mode            = diff_reg;
	assign conversion_done_flag = done_reg;

	// ====================================================
	// Checks
	sel_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL8
		busy_reg && $past(busy_reg) |-> $stable(ref_reg))
		else $error("reference changed during conversion");
	mux_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL11
		busy_reg && $past(busy_reg) |-> $stable(mux_reg))
		else $error("channel changed during conversion");
	done_set_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL16
		fin_edge |=> done_reg)
		else $error("done flag not set on finish");
	lock_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL17
		lock_reg && !rd_hi |=> $stable(result_reg))
		else $error("result updated while locked");
	left_fmt_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL18
		left_j |-> high_byte == result_reg[9:2] && low_byte[7:6] == result_reg[1:0])
		else $error("left layout wrong");
	zero_fill_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL19
		!left_j |-> high_byte[7:2] == 6'h00)
		else $error("unused bits not zero");
	diff_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL3
		!busy_reg |=> diff_reg == ($past(sel_reg[`AIS_SEL_MUX_HI:0]) >= `AIS_CODE_G10_FIRST
			&& $past(sel_reg[`AIS_SEL_MUX_HI:0]) <= `AIS_CODE_U2_LAST))
		else $error("differential flag wrong");
	ref_load_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL7
		!busy_reg |=> ref_reg == $past(sel_reg[`AIS_SEL_REF_HI:`AIS_SEL_REF_LO]))
		else $error("reference not loaded");
	done_live_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL6
		done_reg && !$past(done_reg) |-> $past(fin_edge))
		else $error("done without finish");

	// ====================================================
	// Checks on result layout and result loading
	right_fmt_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL18
		!left_j |-> high_byte[1:0] == result_reg[9:8] && low_byte == result_reg[7:0])
		else $error("right layout wrong");
	left_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL19
		left_j |-> low_byte[5:0] == 6'h00)
		else $error("left unused bits not zero");
	result_load_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL4
		upd_ok |=> result_reg == $past(code_s2_reg))
		else $error("result not loaded");
	sign_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL5
		upd_ok |=> result_reg[`AIS_SIGN_BIT] == $past(code_s2_reg[`AIS_SIGN_BIT]))
		else $error("sign bit wrong");
	// Read lock and done clear
	lock_set_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL17
		rd_lo |=> lock_reg)
		else $error("low read did not lock");
	lock_free_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL17
		rd_hi |=> !lock_reg)
		else $error("high read did not unlock");
	done_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL16
		done_clr && !fin_edge |=> !done_reg)
		else $error("done flag not cleared");
	// Load timing of the analog selections
	start_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL20
		conv_start |-> busy_reg && !$past(busy_reg))
		else $error("start without idle");
	busy_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL8
		wr_sel && busy_reg |=> $stable(ref_reg))
		else $error("reference taken while busy");
endmodule // ais_top

// ---- bench/ais_analog_model.sv ----
`timescale 1ns/1ns
// ====================================================
// Analog side: answers a start with a finish level and a code
module ais_analog_model (
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic       conv_start,
	input  wire logic [9:0] code_in,
	input  wire logic [7:0] lat,
	output logic            conv_finish,
	output logic      [9:0] conv_code
);
	logic [7:0] cnt;
	logic [3:0] hold;
	// Latency count, finish held with a stable code, then released
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 8'h00;
			hold <= 4'h0;
			conv_finish <= 1'b0;
			conv_code <= 10'h155;
		end else if (conv_start) begin
			cnt <= lat;
		end else if (cnt > 8'h01) begin
			cnt <= cnt - 8'h01;
		end else if (cnt == 8'h01) begin
			cnt <= 8'h00;
			hold <= 4'h6;
			conv_finish <= 1'b1;
			conv_code <= code_in;
		end else if (hold == 4'h1) begin
			hold <= 4'h0;
			conv_finish <= 1'b0;
			conv_code <= ~conv_code; // Released code no longer valid
		end else if (hold != 4'h0) begin
			hold <= hold - 4'h1;
		end
	end
endmodule // ais_analog_model

// ---- bench/tb_top.sv ----
`timescale 1ns/1ns
`include "ais_defines.svh"
// ====================================================
// Bench for input select and result formatting
module tb_top
	import ais_pkg::*;
	;
	logic        sys_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, conv_finish, conv_start, diff_mode, conversion_done_flag;
	logic [9:0]  code_in = 10'h000, conv_code;
	logic [7:0]  lat = 8'h04;
	ais_ref_t    reference_select;
	ais_gain_t   gain_select;
	ais_src_t    source_kind;
	logic [2:0]  pos_input, neg_input;
	logic [33:0] exp_q[$];
	logic [33:0] note;
	int          n_fail = 0;
	int          compares = 0;

	always #2 sys_clk = ~sys_clk;

	ais_top dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.conv_finish(conv_finish), .conv_code(conv_code), .conv_start(conv_start),
		.reference_select(reference_select), .pos_input(pos_input), .neg_input(neg_input),
		.gain_select(gain_select), .source_kind(source_kind), .diff_mode(diff_mode),
		.conversion_done_flag(conversion_done_flag));
	ais_analog_model model_u (.sys_clk(sys_clk), .rst_b(rst_b), .conv_start(conv_start),
		.code_in(code_in), .lat(lat), .conv_finish(conv_finish), .conv_code(conv_code));

	// ====================================================
	// Checking and bus tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic complete_run;
		$display("Checks %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// One APB transfer; the expected answer is noted first
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
		int n;
		exp_q.push_back(e);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			chk("pready timeout", 32'h1, 32'h0);
			void'(exp_q.pop_back());
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, {2'b00, 32'h0});
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, {2'b10, e});
	endtask
	// Each answer is matched against the oldest note
	always @(posedge sys_clk) begin
		if (psel && penable && pready === 1'b1) begin
			if (exp_q.size() == 0) chk("queue", 32'h1, 32'h0);
			else begin
				note = exp_q.pop_front();
				chk("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
				if (note[33]) chk("prdata", note[31:0], prdata);
			end
		end
	end
	// Expected result bytes and ideal codes (millivolts)
	function automatic logic [31:0] rbyte(input logic [9:0] r, input logic lj, input logic hi);
		if (lj) return hi ? {24'h0, r[9:2]} : {24'h0, r[1:0], 6'h00};
		return hi ? {30'h0, r[9:8]} : {24'h0, r[7:0]};
	endfunction
	function automatic logic [9:0] se_code(input int vin, input int vref);
		int v;
		v = vin * 1024 / vref;
		return (v > 1023) ? 10'h3ff : v[9:0];
	endfunction
	function automatic logic [9:0] df_code(input int vp, input int vn, input int g, input int vref);
		int v;
		v = (vp - vn) * g * 512 / vref;
		return v[9:0];
	endfunction
	// Conversion start and completion with done flag handling
	task automatic start_conv(input logic [9:0] c, input logic [7:0] l);
		code_in <= c;
		lat <= l;
		wr(`AIS_ADDR_CTRL, 32'h1);
	endtask
	task automatic end_conv(input logic chkd);
		int n;
		n = 0;
		while (conv_finish !== 1'b1 && n < 300) begin
			@(posedge sys_clk);
			n++;
		end
		while (conv_finish === 1'b1 && n < 300) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 300) chk("finish timeout", 32'h1, 32'h0);
		repeat (4) @(posedge sys_clk);
		if (chkd) chk("done", 32'h1, {31'h0, conversion_done_flag});
		wr(`AIS_ADDR_CTRL, 32'h2);
		repeat (2) @(posedge sys_clk);
		chk("done clear", 32'h0, {31'h0, conversion_done_flag});
	endtask

	// ====================================================
	// Main sequence
	initial begin
		logic [9:0] r;
		logic [4:0] c;
		logic [2:0] b;
		int v;
		void'($urandom(84));
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		chk("ref reset", 32'h0, {30'h0, reference_select});
		rd(`AIS_ADDR_SELECT, 32'h0);
		apb(1'b0, 12'h010, 32'h0, {2'b11, 32'h0});
		for (int i = 0; i < 32; i++) begin
			c = i[4:0];
			b = {c[2], 2'b00} >> 1;
			wr(`AIS_ADDR_SELECT, {24'h0, c[1:0], 1'b0, c});
			rd(`AIS_ADDR_SELECT, {24'h0, c[1:0], 1'b0, c});
			chk("ref", {30'h0, c[1:0]}, {30'h0, reference_select});
			chk("diff", {31'h0, c >= 5'h08 && c <= 5'h1d}, {31'h0, diff_mode});
			if (c < 5'h08) chk("pin", {29'h0, c[2:0]}, {29'h0, pos_input});
			else if (c < 5'h10) begin
				chk("pos", {29'h0, b + {2'b00, c[0]}}, {29'h0, pos_input});
				chk("neg", {29'h0, b}, {29'h0, neg_input});
				chk("gain", c[1] ? 32'h2 : 32'h1, {30'h0, gain_select});
			end else if (c < 5'h1e) begin
				chk("pos", {29'h0, c[2:0]}, {29'h0, pos_input});
				chk("neg", c[3] ? 32'h2 : 32'h1, {29'h0, neg_input});
				chk("gain", 32'h0, {30'h0, gain_select});
			end
			v = (c < 5'h08) ? 0 : (c < 5'h1e) ? 1 : c[0] ? 3 : 2;
			chk("src", v, {30'h0, source_kind});
		end
		wr(`AIS_ADDR_SELECT, 32'hed);
		r = df_code(300, 500, 10, 2560);
		start_conv(r, 8'h05);
		end_conv(1'b1);
		rd(`AIS_ADDR_RES_LOW, rbyte(r, 1'b1, 1'b0));
		rd(`AIS_ADDR_RES_HIGH, rbyte(r, 1'b1, 1'b1));
		wr(`AIS_ADDR_SELECT, 32'hcd);
		rd(`AIS_ADDR_RES_LOW, rbyte(r, 1'b0, 1'b0));
		rd(`AIS_ADDR_RES_HIGH, rbyte(r, 1'b0, 1'b1));
		for (int i = 0; i < 3; i++) begin
			v = (i == 0) ? 0 : (i == 1) ? int'($urandom % 5000) : 5000;
			c = 5'($urandom % 8);
			wr(`AIS_ADDR_SELECT, {24'h0, 3'b010, c});
			r = se_code(v, 5000);
			start_conv(r, 8'($urandom % 20 + 2));
			end_conv(1'b1);
			rd(`AIS_ADDR_RES_LOW, rbyte(r, 1'b0, 1'b0));
			rd(`AIS_ADDR_RES_HIGH, rbyte(r, 1'b0, 1'b1));
		end
		wr(`AIS_ADDR_SELECT, 32'h41);
		start_conv(10'h2cd, 8'h50);
		wr(`AIS_ADDR_SELECT, 32'hea);
		chk("ref held", 32'h1, {30'h0, reference_select});
		chk("mux held", 32'h1, {29'h0, pos_input});
		rd(`AIS_ADDR_CTRL, 32'h4);
		rd(`AIS_ADDR_RES_HIGH, rbyte(r, 1'b1, 1'b1));
		end_conv(1'b1);
		chk("ref new", 32'h3, {30'h0, reference_select});
		chk("gain new", 32'h2, {30'h0, gain_select});
		rd(`AIS_ADDR_RES_LOW, rbyte(10'h2cd, 1'b1, 1'b0));
		rd(`AIS_ADDR_RES_HIGH, rbyte(10'h2cd, 1'b1, 1'b1));
		wr(`AIS_ADDR_SELECT, 32'h40);
		start_conv(10'h123, 8'h03);
		end_conv(1'b1);
		rd(`AIS_ADDR_RES_LOW, 32'h23);
		start_conv(10'h0ab, 8'h03);
		end_conv(1'b0);
		rd(`AIS_ADDR_RES_HIGH, 32'h01);
		start_conv(10'h1e4, 8'h03);
		end_conv(1'b1);
		rd(`AIS_ADDR_RES_LOW, 32'he4);
		rd(`AIS_ADDR_RES_HIGH, 32'h01);
		complete_run;
	end
	// Watchdog against a hang
	initial begin
		#40000;
		chk("watchdog", 32'h0, 32'h1);
		complete_run;
	end
endmodule // tb_top
